/* File: shared/dsp_dp_map.svh */
// Offsets, reset values and widths of the min-load / multiply-load datapath.
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr.
`ifndef DSP_DP_MAP_SVH
`define DSP_DP_MAP_SVH
// Datapath widths
`define ACC_W 24
`define MA_W 52
`define P_W 48
`define GUARD_LSB 47
// Register byte offsets (accumulators and X/Y take four words each)
`define OFS_ACC0 8'h00
`define OFS_XY0 8'h10
`define OFS_RP0 8'h20
`define OFS_MA0_LO 8'h30
`define OFS_MA0_HI 8'h34
`define OFS_MA1_LO 8'h38
`define OFS_MA1_HI 8'h3c
`define OFS_P_LO 8'h40
`define OFS_P_HI 8'h44
`define OFS_FLAGS 8'h48
`define OFS_CTRL 8'h4c
`define OFS_COUNT 8'h50
// Field positions
`define CTRL_EN_BIT 0
`define FLAGS_W 7
// Reset values
`define RST_ACC 24'h000000
`define RST_CTRL_EN 1'b1
`define RST_FLAGS 7'h00
`endif

/* File: shared/dsp_dp_pkg.sv */
// Types shared by the datapath and its compare unit.
// Assumes the constant header is on the include path.
`include "dsp_dp_map.svh"
package dsp_dp_pkg;
  // Instruction families, one-hot
  typedef enum logic [3:0]
  {
    OP_MIN_REG = 4'b0001,
    OP_MIN_PLOAD = 4'b0010,
    OP_MLD = 4'b0100,
    OP_MLD_PMOVE = 4'b1000
  } op_t;
  // Parallel-move sources of the multiply-load
  typedef enum logic [1:0]
  {
    PM_MEM = 2'h0,
    PM_HIGH_HALF = 2'h1,
    PM_HIGH_HALF_SHIFT_RIGHT = 2'h2,
    PM_HIGH_HALF_SHIFT_LEFT = 2'h3
  } pm_src_t;
  // One issued instruction word, decoded by the host
  typedef struct packed {
    op_t op;
    logic dest_accumulator;
    logic use_companion;
    logic source_accumulator;
    logic [1:0] active_memory_pointer;
    logic [3:0] ptr_step;
    logic target_mult_accumulator;
    logic x_operand_reg;
    logic y_operand_reg;
    pm_src_t pm_src;
    logic [2:0] pm_dest;
    logic [`ACC_W-1:0] mem_data;
  } instr_t;
  // Condition flags, carry in bit 0
  typedef struct packed {
    logic sticky_guard_overflow;
    logic guard_overflow_flag_second;
    logic guard_overflow_flag_first;
    logic n;
    logic v;
    logic z;
    logic c;
  } flags_t;
  // Compare unit answer
  typedef struct packed {
    logic le;
    logic c;
    logic z;
    logic v;
    logic n;
  } cmp_res_t;
endpackage

/* File: rtl/min_compare_unit.sv */
// Signed 24-bit compare for the conditional minimum load.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_dp_map.svh"
module min_compare_unit
  import dsp_dp_pkg::*;
(
  // Operands
  input wire logic [`ACC_W-1:0] operand,
  input wire logic [`ACC_W-1:0] acc,
  // Result
  output cmp_res_t res
);
  // Operand minus accumulator, carry out in the top bit
  wire logic [`ACC_W:0] diff;
  wire logic ovf;
  assign diff = {1'b0, operand} + {1'b0, ~acc} + {{`ACC_W{1'b0}}, 1'b1};
  // Overflow when signs differ and result sign leaves the operand's
  assign ovf = (operand[`ACC_W-1] ^ acc[`ACC_W-1]) & (diff[`ACC_W-1] ^ operand[`ACC_W-1]);
  assign res.c = diff[`ACC_W];
  assign res.z = (diff[`ACC_W-1:0] == `RST_ACC);
  assign res.v = ovf;
  assign res.n = ovf ^ diff[`ACC_W-1];
  // True sign of the difference is n; so operand <= acc is n or z
  assign res.le = res.n | res.z;
endmodule // min_compare_unit
`default_nettype wire

/* File: rtl/dsp_minload_multload_datapath.sv */
// Conditional minimum load and multiply-load datapath slice with APB register access.
// Assumes instructions arrive decoded from logic on core_clk and memory data rides with them.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_dp_map.svh"
module dsp_minload_multload_datapath
  import dsp_dp_pkg::*;
#(
  parameter int PTR_W = 16
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction issue from the host core
  input wire logic instr_valid,
  input wire instr_t instr,
  // Status
  output logic instr_done,
  output flags_t flags
);
  // Register word is mapped
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= `OFS_COUNT);
  endfunction
  // Guard bits disagree with the sign bit below them
  function automatic logic guard_ovf(input logic [`MA_W-1:0] m);
    guard_ovf = ~((&m[`MA_W-1:`GUARD_LSB]) | ~(|m[`MA_W-1:`GUARD_LSB]));
  endfunction
  // Architectural state
  logic [`ACC_W-1:0] acc_r [0:3];
  logic [`ACC_W-1:0] acc_nxt [0:3];
  logic [`ACC_W-1:0] xy_r [0:3];
  logic [`ACC_W-1:0] xy_nxt [0:3];
  logic [PTR_W-1:0] rp_r [0:3];
  logic [PTR_W-1:0] rp_nxt [0:3];
  logic [`MA_W-1:0] ma_r [0:1];
  logic [`MA_W-1:0] ma_nxt [0:1];
  logic [`P_W-1:0] p_r;
  logic [`P_W-1:0] p_nxt;
  flags_t flags_r;
  flags_t flags_nxt;
  logic en_r;
  logic en_nxt;
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  // Bus phase decode
  wire logic setup_ph;
  wire logic wr_go;
  wire logic wmap;
  assign setup_ph = psel & ~penable;
  assign wmap = is_mapped(paddr);
  // Write takes effect only at the access edge that sees pready
  assign wr_go = psel & penable & pready & pwrite & wmap;
  // Instruction decode
  wire logic go;
  wire logic is_min;
  wire logic is_pload;
  wire logic is_mld;
  wire logic is_pmove;
  assign go = instr_valid & en_r;
  assign is_min = go & ((instr.op == OP_MIN_REG) | (instr.op == OP_MIN_PLOAD));
  assign is_pload = go & (instr.op == OP_MIN_PLOAD);
  assign is_mld = go & ((instr.op == OP_MLD) | (instr.op == OP_MLD_PMOVE));
  assign is_pmove = go & (instr.op == OP_MLD_PMOVE);
  // Accumulator indices: A=0, B=1, C=2, D=3
  wire logic [1:0] dst_idx;
  wire logic [1:0] src_idx;
  wire logic [1:0] comp_idx;
  assign dst_idx = {1'b0, instr.dest_accumulator};
  assign src_idx = {1'b1, instr.source_accumulator};
  assign comp_idx = {1'b0, ~instr.dest_accumulator};
  wire logic [`ACC_W-1:0] min_operand;
  assign min_operand = ((instr.op == OP_MIN_REG) && instr.use_companion) ? acc_r[comp_idx] : acc_r[src_idx];
  // Compare and flags of the minimum load
  cmp_res_t cmp;
  min_compare_unit u_cmp
  (
    .operand (min_operand),
    .acc (acc_r[dst_idx]),
    .res (cmp)
  );
  // Pointer post-modify for the memory access of this word
  wire logic [1:0] ptr;
  wire logic [PTR_W-1:0] ptr_next;
  assign ptr = instr.active_memory_pointer;
  assign ptr_next = rp_r[ptr] + {{(PTR_W-4){instr.ptr_step[3]}}, instr.ptr_step};
  // Multiplier operands and product
  wire logic [`ACC_W-1:0] x_op;
  wire logic [`ACC_W-1:0] y_op;
  wire logic [`P_W-1:0] product;
  assign x_op = xy_r[{1'b0, instr.x_operand_reg}];
  assign y_op = xy_r[{1'b1, instr.y_operand_reg}];
  assign product = $signed(x_op) * $signed(y_op);
  // Value moved into the multiplier accumulator, with one spare bit
  wire logic [`MA_W:0] ma_load;
  wire logic tgt;
  wire logic vm_new;
  wire logic mv_set;
  assign tgt = instr.target_mult_accumulator;
  // old product sign-extended to accumulator width
  assign ma_load = {{(`MA_W-`P_W+1){p_r[`P_W-1]}}, p_r};
  assign vm_new = guard_ovf(ma_load[`MA_W-1:0]);
  assign mv_set = ma_load[`MA_W] ^ ma_load[`MA_W-1];
  // Parallel-move source: memory or the other multiplier accumulator
  wire logic [`MA_W-1:0] ma_oth;
  wire logic [`ACC_W-1:0] pm_val;
  wire logic pm_ovf;
  wire logic pm_dst_acc;
  assign ma_oth = ma_r[~tgt];
  assign pm_dst_acc = ~instr.pm_dest[2];
  // memory or high half; shift it by one
  assign pm_val = (instr.pm_src == PM_MEM) ? instr.mem_data :
                  (instr.pm_src == PM_HIGH_HALF) ? ma_oth[47:24] :
                  (instr.pm_src == PM_HIGH_HALF_SHIFT_RIGHT) ? {ma_oth[47], ma_oth[47:25]} :
                  {ma_oth[46:24], 1'b0};
  // load overflow when the value does not fit 24 bits
  assign pm_ovf = (instr.pm_src == PM_MEM) ? 1'b0 :
                  (instr.pm_src == PM_HIGH_HALF_SHIFT_LEFT) ? (guard_ovf(ma_oth) | (ma_oth[47] ^ ma_oth[46])) :
                  guard_ovf(ma_oth);
  // Next state: bus write first, instruction on top so hardware wins
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      acc_nxt[i] = acc_r[i];
      xy_nxt[i] = xy_r[i];
      rp_nxt[i] = rp_r[i];
    end
    for (int j = 0; j < 2; j++)
    begin
      ma_nxt[j] = ma_r[j];
    end
    p_nxt = p_r;
    flags_nxt = flags_r;
    en_nxt = en_r;
    count_nxt = count_r;
    // Software preset of state
    if (wr_go)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (paddr == (`OFS_ACC0 + 8'(4 * i)))
        begin
          acc_nxt[i] = pwdata[`ACC_W-1:0];
        end
        if (paddr == (`OFS_XY0 + 8'(4 * i)))
        begin
          xy_nxt[i] = pwdata[`ACC_W-1:0];
        end
        if (paddr == (`OFS_RP0 + 8'(4 * i)))
        begin
          rp_nxt[i] = pwdata[PTR_W-1:0];
        end
      end
      case (paddr)
        `OFS_MA0_LO: ma_nxt[0][31:0] = pwdata;
        `OFS_MA0_HI: ma_nxt[0][`MA_W-1:32] = pwdata[`MA_W-33:0];
        `OFS_MA1_LO: ma_nxt[1][31:0] = pwdata;
        `OFS_MA1_HI: ma_nxt[1][`MA_W-1:32] = pwdata[`MA_W-33:0];
        `OFS_P_LO: p_nxt[31:0] = pwdata;
        `OFS_P_HI: p_nxt[`P_W-1:32] = pwdata[`P_W-33:0];
        `OFS_FLAGS: flags_nxt = flags_t'(pwdata[`FLAGS_W-1:0]);
        `OFS_CTRL: en_nxt = pwdata[`CTRL_EN_BIT];
        `OFS_COUNT: count_nxt = pwdata;
        default: ;
      endcase
    end
    // Minimum load
    if (is_min)
    begin
      flags_nxt.c = cmp.c;
      flags_nxt.z = cmp.z;
      flags_nxt.v = cmp.v;
      flags_nxt.n = cmp.n;
      // source refilled from memory, pointer stepped
      if (is_pload)
      begin
        acc_nxt[src_idx] = instr.mem_data;
        rp_nxt[ptr] = ptr_next;
      end
      // load only when operand is not above
      if (cmp.le)
      begin
        acc_nxt[dst_idx] = min_operand;
        rp_nxt[3] = rp_r[ptr];
      end
    end
    // Multiply-load
    if (is_mld)
    begin
      ma_nxt[tgt] = ma_load[`MA_W-1:0];
      // new product replaces the old one
      p_nxt = product;
      if (tgt)
      begin
        flags_nxt.guard_overflow_flag_second = vm_new;
      end
      else
      begin
        flags_nxt.guard_overflow_flag_first = vm_new;
      end
      if (mv_set)
      begin
        flags_nxt.sticky_guard_overflow = 1'b1;
      end
    end
    // Parallel move of the multiply-load
    if (is_pmove)
    begin
      if (instr.pm_src == PM_MEM)
      begin
        rp_nxt[ptr] = ptr_next;
      end
      if (pm_dst_acc)
      begin
        acc_nxt[instr.pm_dest[1:0]] = pm_val;
        flags_nxt.z = (pm_val == `RST_ACC);
        flags_nxt.v = pm_ovf;
        flags_nxt.n = pm_val[`ACC_W-1];
      end
      else
      begin
        xy_nxt[instr.pm_dest[1:0]] = pm_val;
      end
    end
    // Executed instruction count
    if (go)
    begin
      count_nxt = count_r + 32'h00000001;
    end
  end
  // Read mux for the setup cycle
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h00000000;
    case (paddr)
      `OFS_ACC0: rd_word = {8'h00, acc_r[0]};
      8'h04: rd_word = {8'h00, acc_r[1]};
      8'h08: rd_word = {8'h00, acc_r[2]};
      8'h0c: rd_word = {8'h00, acc_r[3]};
      `OFS_XY0: rd_word = {8'h00, xy_r[0]};
      8'h14: rd_word = {8'h00, xy_r[1]};
      8'h18: rd_word = {8'h00, xy_r[2]};
      8'h1c: rd_word = {8'h00, xy_r[3]};
      `OFS_RP0: rd_word = 32'(rp_r[0]);
      8'h24: rd_word = 32'(rp_r[1]);
      8'h28: rd_word = 32'(rp_r[2]);
      8'h2c: rd_word = 32'(rp_r[3]);
      `OFS_MA0_LO: rd_word = ma_r[0][31:0];
      `OFS_MA0_HI: rd_word = {12'h000, ma_r[0][`MA_W-1:32]};
      `OFS_MA1_LO: rd_word = ma_r[1][31:0];
      `OFS_MA1_HI: rd_word = {12'h000, ma_r[1][`MA_W-1:32]};
      `OFS_P_LO: rd_word = p_r[31:0];
      `OFS_P_HI: rd_word = {16'h0000, p_r[`P_W-1:32]};
      `OFS_FLAGS: rd_word = {25'h0000000, flags_r};
      `OFS_CTRL: rd_word = {31'h00000000, en_r};
      `OFS_COUNT: rd_word = count_r;
      default: rd_word = 32'h00000000;
    endcase
  end
  // every update of one word lands on one edge
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 4; i++)
      begin
        acc_r[i] <= `RST_ACC;
        xy_r[i] <= `RST_ACC;
        rp_r[i] <= '0;
      end
      ma_r[0] <= '0;
      ma_r[1] <= '0;
      p_r <= '0;
      flags_r <= flags_t'(`RST_FLAGS);
      en_r <= `RST_CTRL_EN;
      count_r <= 32'h00000000;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        acc_r[i] <= acc_nxt[i];
        xy_r[i] <= xy_nxt[i];
        rp_r[i] <= rp_nxt[i];
      end
      ma_r[0] <= ma_nxt[0];
      ma_r[1] <= ma_nxt[1];
      p_r <= p_nxt;
      flags_r <= flags_nxt;
      en_r <= en_nxt;
      count_r <= count_nxt;
    end
  end

  // Bus answer prepared in setup, shown during the access phase; the outputs are the flops
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      instr_done <= 1'b0;
    end
    else
    begin
      pready <= setup_ph;
      pslverr <= setup_ph & ~wmap;
      // Unmapped and write cycles read as zero
      prdata <= (setup_ph & ~pwrite) ? rd_word : 32'h00000000;
      // Completion pulse, one cycle after each executed word
      instr_done <= go;
    end
  end
  // Flag word straight from its flop
  assign flags = flags_r;
endmodule // dsp_minload_multload_datapath
`default_nettype wire

/* File: sim/dsp_dp_props.sv */
// Port checker for the min-load / multiply-load datapath.
// Bound from the testbench top; sees only the datapath's ports.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_dp_map.svh"
module dsp_dp_props
  import dsp_dp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Instructions and status
  input wire logic instr_valid,
  input wire instr_t instr,
  input wire logic instr_done,
  input wire flags_t flags
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // Software store into the flag word
  wire logic flags_wr;
  assign flags_wr = psel && penable && pready && pwrite && (paddr == `OFS_FLAGS);
  // Address outside the map or not word aligned
  wire logic bad_addr;
  assign bad_addr = (paddr > `OFS_COUNT) || (paddr[1:0] != 2'h0);
  // APB setup cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  // Multiply-load aimed at one multiplier accumulator
  sequence s_mld(t);
    instr_valid && (instr.op inside {OP_MLD, OP_MLD_PMOVE}) && (instr.target_mult_accumulator == t);
  endsequence
  AST_PREADY_ANSWER: // access phase is one cycle
    assert property (s_setup |=> pready) else $error("pready missing after setup");
  AST_PREADY_ONE: // ready stands one cycle
    assert property (pready |-> $past(psel && !penable) ##1 !pready) else $error("pready not single");
  AST_SLVERR_ADDR: // refusal follows the address
    assert property (s_setup |=> (pslverr == $past(bad_addr))) else $error("pslverr mismatch");
  AST_DONE_CAUSE:
    assert property (instr_done |-> $past(instr_valid)) else $error("done without a word");
  AST_DONE_IDLE:
    assert property (!instr_valid |=> !instr_done) else $error("done while idle");
  AST_STICKY_HOLDS:
    assert property ($fell(flags.sticky_guard_overflow) |-> $past(flags_wr)) else $error("sticky flag fell");
  AST_GUARD_OTHER:
    assert property (s_mld(1'b0) |=> $stable(flags.guard_overflow_flag_second)) else $error("wrong guard flag");
  AST_MLD_KEEPS:
    assert property (instr_valid && (instr.op == OP_MLD || (instr.op == OP_MLD_PMOVE && instr.pm_dest[2]))
      |=> $stable({flags.c, flags.z, flags.v, flags.n, flags.sticky_guard_overflow})) else $error("flags moved");
  AST_PMOVE_CARRY:
    assert property (s_mld(1'b1) or s_mld(1'b0) |=> $stable(flags.c)) else $error("carry moved");
  AST_MIN_ZERO:
    assert property (instr_valid && (instr.op inside {OP_MIN_REG, OP_MIN_PLOAD})
      |=> !flags.z || (flags.c && !flags.v && !flags.n)) else $error("zero result flags wrong");
endmodule // dsp_dp_props
`default_nettype wire

/* File: sim/host_issue_model.sv */
// Host core model issuing decoded words to the datapath.
// Drives just after rising edges of the shared core clock.
`timescale 1ns/1ps
`default_nettype none
module host_issue_model
  import dsp_dp_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Issue port
  output logic instr_valid,
  output instr_t instr
);
  // Idle until the first word
  initial
  begin
    instr_valid = 1'b0;
    instr = '0;
  end
  // Issue words back to back, one per cycle
  task automatic run(input instr_t list[$]);
    instr_t w;
    foreach (list[k])
    begin
      w = list[k];
      if (w.op == OP_MIN_PLOAD && w.active_memory_pointer == 2'h3)
        w.active_memory_pointer = 2'h0;
      @(posedge core_clk);
      instr_valid <= 1'b1;
      instr <= w;
    end
    @(posedge core_clk);
    instr_valid <= 1'b0;
    // Stale word scrambled so nothing leans on it
    instr <= instr_t'(~w);
  endtask
endmodule // host_issue_model
`default_nettype wire

/* File: sim/dsp_minload_multload_datapath_tb.sv */
// Self-checking bench for the min-load / multiply-load datapath.
// Registers over APB; words come from the host model.
`timescale 1ns/1ps
`default_nettype none
`include "dsp_dp_map.svh"
module dsp_minload_multload_datapath_tb
  import dsp_dp_pkg::*;
;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  // Clock, reset, APB
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Instruction side
  logic instr_valid;
  instr_t instr;
  logic instr_done;
  flags_t flags;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  instr_t w;
  instr_t v;
  logic ld;
  // Compare cases: operand, accumulator
  logic [23:0] mop [5] = '{24'h000003, 24'h000007, 24'h000004, 24'h7fffff, 24'h800000};
  logic [23:0] mac [5] = '{24'h000005, 24'h000003, 24'h000004, 24'h800000, 24'h000001};
  // Parallel-move cases
  pm_src_t psrc [5] = '{PM_HIGH_HALF_SHIFT_RIGHT, PM_HIGH_HALF_SHIFT_LEFT, PM_HIGH_HALF, PM_MEM, PM_MEM};
  logic [23:0] pval [5] = '{24'hc00001, 24'h000004, 24'h800002, 24'h000000, 24'h000777};
  logic [6:0] pfl [5] = '{7'h49, 7'h45, 7'h49, 7'h43, 7'h43};
  always #2 core_clk = ~core_clk;
  dsp_minload_multload_datapath uut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_valid(instr_valid), .instr(instr), .instr_done(instr_done), .flags(flags));
  host_issue_model host (.core_clk(core_clk), .instr_valid(instr_valid), .instr(instr));
  // Expected {N,V,Z,C} of operand minus accumulator
  function automatic logic [3:0] min_flags(input logic [23:0] o, input logic [23:0] a);
    logic [24:0] s;
    logic ov;
    s = {1'b0, o} + {1'b0, ~a} + 25'h1;
    ov = (o[23] != a[23]) && (s[23] != o[23]);
    return {ov ^ s[23], ov, s[23:0] == 24'h0, s[24]};
  endfunction
  // One APB transfer; reads compare against d
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    comparisons++;
    if (pslverr !== err || (!wr && prdata !== d))
    begin
      bad_count++;
      $display("[FAIL] %0t addr %h read %h err %b", $time, a, prdata, pslverr);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Status ports one cycle after the last word was offered
  task automatic port_check(input logic done, input logic [6:0] fl);
    @(posedge core_clk);
    comparisons++;
    if (instr_done !== done || flags !== fl)
    begin
      bad_count++;
      $display("[FAIL] %0t done %b flags %h", $time, instr_done, flags);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles needed
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      bad_count++;
      $display("[FAIL] %0t timeout", $time);
      report_and_stop();
    end
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    apb(RD, `OFS_ACC0, {8'h0, `RST_ACC}, 1'b0);
    apb(RD, `OFS_CTRL, {31'h0, `RST_CTRL_EN}, 1'b0);
    apb(RD, `OFS_FLAGS, {25'h0, `RST_FLAGS}, 1'b0);
    apb(RD, 8'h54, 32'h0, 1'b1);
    apb(WR, 8'h01, 32'h55, 1'b1);
    apb(RD, `OFS_ACC0, 32'h0, 1'b0);
    // Register-form compares, companion on odd cases
    for (int k = 0; k < 5; k++)
    begin
      apb(WR, `OFS_ACC0, {8'h0, mac[k]}, 1'b0);
      apb(WR, 8'h04, {8'h0, mop[k]}, 1'b0);
      apb(WR, 8'h08, {8'h0, k[0] ? ~mop[k] : mop[k]}, 1'b0);
      apb(WR, 8'h24, 32'(32'h1000 + k), 1'b0);
      apb(WR, 8'h2c, 32'hffff, 1'b0);
      w = '0;
      w.op = OP_MIN_REG;
      w.use_companion = k[0];
      w.active_memory_pointer = 2'h1;
      host.run('{w});
      ld = $signed(mop[k]) <= $signed(mac[k]);
      apb(RD, `OFS_ACC0, {8'h0, ld ? mop[k] : mac[k]}, 1'b0);
      apb(RD, 8'h2c, ld ? 32'(32'h1000 + k) : 32'hffff, 1'b0);
      apb(RD, `OFS_FLAGS, {28'h0, min_flags(mop[k], mac[k])}, 1'b0);
    end
    // Parallel-load form through pointer 0
    apb(WR, 8'h04, 32'h100, 1'b0);
    apb(WR, 8'h0c, 32'h50, 1'b0);
    apb(WR, 8'h20, 32'h10, 1'b0);
    w = '0;
    w.op = OP_MIN_PLOAD;
    w.dest_accumulator = 1'b1;
    w.source_accumulator = 1'b1;
    w.ptr_step = 4'h1;
    w.mem_data = 24'h00abcd;
    host.run('{w});
    port_check(1'b1, {3'h0, min_flags(24'h50, 24'h100)});
    apb(RD, 8'h04, 32'h50, 1'b0);
    apb(RD, 8'h0c, 32'habcd, 1'b0);
    apb(RD, 8'h2c, 32'h10, 1'b0);
    apb(RD, 8'h20, 32'h11, 1'b0);
    apb(RD, `OFS_FLAGS, {28'h0, min_flags(24'h50, 24'h100)}, 1'b0);
    // Disabled block ignores the word
    apb(WR, `OFS_CTRL, 32'h0, 1'b0);
    apb(WR, 8'h0c, 32'h1, 1'b0);
    host.run('{w});
    port_check(1'b0, {3'h0, min_flags(24'h50, 24'h100)});
    apb(RD, 8'h04, 32'h50, 1'b0);
    apb(WR, `OFS_CTRL, 32'h1, 1'b0);
    // Back-to-back multiply-loads, both guard flags preset
    apb(WR, `OFS_FLAGS, 32'h70, 1'b0);
    apb(WR, `OFS_P_LO, 32'h12345678, 1'b0);
    apb(WR, `OFS_P_HI, 32'h8000, 1'b0);
    apb(WR, 8'h10, 32'h3, 1'b0);
    apb(WR, 8'h18, 32'hfffffe, 1'b0);
    apb(WR, 8'h14, 32'h2, 1'b0);
    w = '0;
    w.op = OP_MLD;
    v = w;
    v.target_mult_accumulator = 1'b1;
    v.x_operand_reg = 1'b1;
    host.run('{w, v});
    port_check(1'b1, 7'h40);
    apb(RD, `OFS_MA0_LO, 32'h12345678, 1'b0);
    apb(RD, `OFS_MA0_HI, 32'h000f8000, 1'b0);
    apb(RD, `OFS_MA1_LO, 32'hfffffffa, 1'b0);
    apb(RD, `OFS_MA1_HI, 32'h000fffff, 1'b0);
    apb(RD, `OFS_P_HI, 32'h0000ffff, 1'b0);
    apb(RD, `OFS_P_LO, 32'hfffffffc, 1'b0);
    apb(RD, `OFS_FLAGS, 32'h40, 1'b0);
    // Parallel moves from the other accumulator and memory
    apb(WR, `OFS_MA1_LO, 32'h02000000, 1'b0);
    apb(WR, `OFS_MA1_HI, 32'h000f8000, 1'b0);
    apb(WR, `OFS_FLAGS, 32'h41, 1'b0);
    for (int k = 0; k < 5; k++)
    begin
      w = '0;
      w.op = OP_MLD_PMOVE;
      w.pm_src = psrc[k];
      w.pm_dest = 3'(k);
      w.active_memory_pointer = 2'h2;
      w.mem_data = (psrc[k] == PM_MEM) ? pval[k] : 24'h5a5a5a;
      host.run('{w});
      apb(RD, 8'(4 * k), {8'h0, pval[k]}, 1'b0);
      apb(RD, `OFS_FLAGS, {25'h0, pfl[k]}, 1'b0);
    end
    // Software clear of the sticky flag, then the executed word count
    apb(WR, `OFS_FLAGS, 32'h0, 1'b0);
    apb(RD, `OFS_FLAGS, 32'h0, 1'b0);
    apb(RD, `OFS_COUNT, 32'h0000000d, 1'b0);
    report_and_stop();
  end
endmodule // dsp_minload_multload_datapath_tb
bind dsp_minload_multload_datapath dsp_dp_props chk (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .instr_valid(instr_valid), .instr(instr), .instr_done(instr_done), .flags(flags));
`default_nettype wire
